//--- inc/dse_pkg.sv
// dse_pkg: encodings, constants and state record of the stream engine
package dse_pkg;
    // =========================================================
    // item sizes, burst lengths, fifo geometry
    // =========================================================
    localparam logic [1:0] DSE_SZ_BYTE = 2'h0;
    localparam logic [1:0] DSE_SZ_HALF = 2'h1;
    localparam logic [1:0] DSE_SZ_WORD = 2'h2;
    localparam logic [1:0] DSE_BURST_SINGLE = 2'h0;
    localparam logic [1:0] DSE_BURST_INCR4 = 2'h1;
    localparam logic [1:0] DSE_BURST_INCR8 = 2'h2;
    localparam logic [1:0] DSE_BURST_INCR16 = 2'h3;
    localparam logic [4:0] DSE_FIFO_BYTES = 5'h10;
    localparam logic [4:0] DSE_THR_STEP = 5'h04;

    // =========================================================
    // sequencer states and the full register record
    // =========================================================
    typedef enum logic [1:0] {
        DSE_IDLE = 2'b00,
        DSE_PERIPH = 2'b01,
        DSE_MEM = 2'b10
    } dse_state_t;

    typedef struct packed {
        dse_state_t st;
        logic enable;
        logic stop_pend;
        logic flush;
        logic ct;
        logic [7:0] req_m;
        logic [7:0] req_s;
        logic [7:0] last_m;
        logic [7:0] last_s;
        logic [15:0] count;
        logic [15:0] reload;
        logic [17:0] mem_left;
        logic [31:0] mem_base_first;
        logic [31:0] mem_base_second;
        logic [31:0] p_cur;
        logic [31:0] m_cur;
        logic [127:0] fifo;
        logic [4:0] fill;
        logic [4:0] beats_left;
        logic half_f;
        logic done_f;
        logic err_f;
        logic irq_half;
        logic irq_done;
        logic irq_err;
        logic [1:0] prio;
        logic p_valid;
        logic p_write;
        logic p_lock;
        logic [1:0] p_size;
        logic [31:0] p_addr;
        logic [31:0] p_wdata;
        logic m_valid;
        logic m_write;
        logic m_lock;
        logic [1:0] m_size;
        logic [31:0] m_addr;
        logic [31:0] m_wdata;
    } dse_regs_t;

    localparam dse_regs_t DSE_REGS_RST = '0;

    // bytes in one item of the given size code
    function automatic logic [4:0] dse_size_bytes(input logic [1:0] s);
        return (s == DSE_SZ_WORD) ? 5'h04 : (s == DSE_SZ_HALF) ? 5'h02 : 5'h01;
    endfunction : dse_size_bytes

    // beats in one access for the given burst code
    function automatic logic [4:0] dse_beats(input logic [1:0] b);
        case (b)
            DSE_BURST_SINGLE: return 5'h01;
            DSE_BURST_INCR4: return 5'h04;
            DSE_BURST_INCR8: return 5'h08;
            default: return 5'h10;
        endcase
    endfunction : dse_beats

    // fifo fill in bytes that the threshold code stands for
    function automatic logic [4:0] dse_thr_bytes(input logic [1:0] t);
        return {1'b0, t, 2'b00} + DSE_THR_STEP;
    endfunction : dse_thr_bytes
endpackage : dse_pkg

//--- core/dse_stream.sv
// dse_stream: one dma stream, peripheral port, memory port, fifo, control
`timescale 1ns/10ps
module dse_stream (
    input logic clk,
    input logic resetn,
    input logic enable_wr,
    input logic enable_wdata,
    input logic count_wr,
    input logic [15:0] count_wdata,
    input logic mem_base_first_wr,
    input logic [31:0] mem_base_first_wdata,
    input logic mem_base_second_wr,
    input logic [31:0] mem_base_second_wdata,
    input logic [31:0] periph_port_address,
    input logic dir_m2p,
    input logic periph_inc,
    input logic mem_inc,
    input logic [1:0] periph_size,
    input logic [1:0] mem_item_size,
    input logic circular,
    input logic double_buf,
    input logic fifo_en,
    input logic [1:0] fifo_thresh,
    input logic [1:0] periph_burst,
    input logic [1:0] mem_burst_length,
    input logic periph_length_control,
    input logic [2:0] request_line_select,
    input logic [1:0] stream_priority_level,
    input logic half_ie,
    input logic done_ie,
    input logic err_ie,
    input logic [2:0] flag_clear,
    input logic [7:0] periph_req,
    input logic [7:0] periph_last,
    output logic stream_enable,
    output logic [15:0] remaining_item_count,
    output logic current_target_sel,
    output logic half_flag,
    output logic done_flag,
    output logic err_flag,
    output logic irq_half,
    output logic irq_done,
    output logic irq_err,
    output logic [1:0] stream_priority,
    output logic p_valid,
    output logic p_write,
    output logic p_lock,
    output logic [1:0] p_size,
    output logic [31:0] p_addr,
    output logic [31:0] p_wdata,
    input logic [31:0] p_rdata,
    input logic p_ready,
    input logic p_err,
    output logic m_valid,
    output logic m_write,
    output logic m_lock,
    output logic [1:0] m_size,
    output logic [31:0] m_addr,
    output logic [31:0] m_wdata,
    input logic [31:0] m_rdata,
    input logic m_ready,
    input logic m_err
);
    // =========================================================
    // derived configuration
    // =========================================================
    dse_pkg::dse_regs_t r;
    dse_pkg::dse_regs_t next_r;
    logic [4:0] psz, msz, pbeats, mbeats, thr, room;
    logic [6:0] p_need, m_need;
    logic p2m, circ, req_sel, last_sel, more, per_beat, mem_beat;
    logic blk_end, per_go, mem_go;
    logic [4:0] mem_n;

    // direct mode pins both ports to single items
    assign psz = dse_pkg::dse_size_bytes(periph_size);
    assign msz = dse_pkg::dse_size_bytes(mem_item_size);
    assign pbeats = fifo_en ? dse_pkg::dse_beats(periph_burst) : 5'h01;
    assign mbeats = fifo_en ? dse_pkg::dse_beats(mem_burst_length) : 5'h01;
    assign thr = fifo_en ? dse_pkg::dse_thr_bytes(fifo_thresh) : msz;
    assign room = dse_pkg::DSE_FIFO_BYTES - r.fill;
    assign p_need = {2'h0, pbeats} * {2'h0, psz};
    assign m_need = {2'h0, mbeats} * {2'h0, msz};
    assign p2m = ~dir_m2p;
    assign circ = circular | double_buf;
    // only the selected line is looked at, after its synchroniser
    assign req_sel = r.req_s[request_line_select];
    assign last_sel = r.last_s[request_line_select];
    assign more = periph_length_control || (r.count != 16'h0);
    assign per_beat = (r.st == dse_pkg::DSE_PERIPH) && r.p_valid && p_ready;
    assign mem_beat = (r.st == dse_pkg::DSE_MEM) && r.m_valid && m_ready;

    // =========================================================
    // next-state logic
    // =========================================================
    always_comb begin
        next_r = r;
        blk_end = 1'b0;
        per_go = 1'b0;
        mem_go = 1'b0;
        mem_n = mbeats;
        // clear first, so a set later in this process wins
        next_r.half_f = r.half_f & ~flag_clear[0];
        next_r.done_f = r.done_f & ~flag_clear[1];
        next_r.err_f = r.err_f & ~flag_clear[2];
        next_r.req_m = periph_req;
        next_r.req_s = r.req_m;
        next_r.last_m = periph_last;
        next_r.last_s = r.last_m;
        // a single stream always wins its own port arbitration
        next_r.prio = stream_priority_level;
        // counter is locked while the stream runs
        if (count_wr && !r.enable) begin
            next_r.count = count_wdata;
            next_r.reload = count_wdata;
        end
        // the active pointer cannot be rewritten under a running stream
        if (mem_base_first_wr && !(r.enable && !r.ct)) begin
            next_r.mem_base_first = mem_base_first_wdata;
        end
        if (mem_base_second_wr && !(r.enable && r.ct)) begin
            next_r.mem_base_second = mem_base_second_wdata;
        end
        if (enable_wr && enable_wdata && !r.enable) begin
            next_r.enable = 1'b1;
            next_r.p_cur = periph_port_address;
            next_r.m_cur = r.ct ? r.mem_base_second : r.mem_base_first;
            next_r.fill = 5'h00;
            next_r.flush = 1'b0;
            next_r.mem_left = {2'h0, r.count} << periph_size;
        end
        // disable only latches a request; the access in flight runs out
        if (enable_wr && !enable_wdata && r.enable) begin
            next_r.stop_pend = 1'b1;
        end
        unique case (r.st)
            dse_pkg::DSE_IDLE: begin
                if (r.enable && r.stop_pend) begin
                    next_r.enable = 1'b0;
                    next_r.stop_pend = 1'b0;
                end else if (r.enable && p2m) begin
                    if (r.flush && r.fill >= thr &&
                        {2'h0, r.fill} >= m_need) begin
                        // a full threshold still leaves as one burst
                        mem_go = 1'b1;
                    end else if (r.flush) begin
                        mem_go = r.fill >= msz;
                        mem_n = 5'h01;
                        blk_end = r.fill < msz;
                    end else if (r.fill >= thr && {2'h0, r.fill} >= m_need) begin
                        mem_go = 1'b1;
                    end else begin
                        per_go = req_sel && more && {2'h0, room} >= p_need;
                    end
                end else if (r.enable) begin
                    if (r.flush) begin
                        blk_end = 1'b1;
                    end else if (req_sel && more && {2'h0, r.fill} >= p_need) begin
                        per_go = 1'b1;
                    end else begin
                        // prefetch while the block still needs memory data
                        mem_go = (periph_length_control ||
                                  r.mem_left >= {11'h0, m_need}) &&
                                 {2'h0, room} >= m_need &&
                                 (fifo_en || r.fill == 5'h00);
                    end
                end
            end
            dse_pkg::DSE_PERIPH: begin
                if (per_beat && p_err) begin
                    next_r.err_f = 1'b1;
                    next_r.enable = 1'b0;
                    next_r.stop_pend = 1'b0;
                    next_r.p_valid = 1'b0;
                    next_r.p_lock = 1'b0;
                    next_r.st = dse_pkg::DSE_IDLE;
                end else if (per_beat) begin
                    if (p2m) begin
                        for (int i = 0; i < 4; i++) begin
                            if (5'(i) < psz) begin
                                next_r.fifo[{4'(r.fill + 5'(i)), 3'h0} +: 8] =
                                    p_rdata[8*i +: 8];
                            end
                        end
                        next_r.fill = r.fill + psz;
                    end else begin
                        next_r.fifo = r.fifo >> {psz, 3'h0};
                        next_r.fill = r.fill - psz;
                    end
                    if (periph_inc) begin
                        next_r.p_cur = r.p_cur + 32'(psz);
                    end
                    if (r.count != 16'h0) begin
                        next_r.count = r.count - 16'h1;
                    end
                    if (!periph_length_control && r.count == 16'h1) begin
                        next_r.flush = 1'b1;
                    end
                    if (!periph_length_control && r.count != 16'h0 &&
                        r.count - 16'h1 == (r.reload >> 1)) begin
                        next_r.half_f = 1'b1;
                    end
                    if (periph_length_control && last_sel) begin
                        next_r.flush = 1'b1;
                    end
                    if (r.beats_left == 5'h01 || next_r.flush) begin
                        next_r.p_valid = 1'b0;
                        next_r.p_lock = 1'b0;
                        next_r.st = dse_pkg::DSE_IDLE;
                    end else begin
                        next_r.beats_left = r.beats_left - 5'h01;
                        next_r.p_addr = next_r.p_cur;
                        next_r.p_wdata = next_r.fifo[31:0];
                    end
                end
            end
            dse_pkg::DSE_MEM: begin
                if (mem_beat && m_err) begin
                    next_r.err_f = 1'b1;
                    next_r.enable = 1'b0;
                    next_r.stop_pend = 1'b0;
                    next_r.m_valid = 1'b0;
                    next_r.m_lock = 1'b0;
                    next_r.st = dse_pkg::DSE_IDLE;
                end else if (mem_beat) begin
                    if (dir_m2p) begin
                        for (int i = 0; i < 4; i++) begin
                            if (5'(i) < msz) begin
                                next_r.fifo[{4'(r.fill + 5'(i)), 3'h0} +: 8] =
                                    m_rdata[8*i +: 8];
                            end
                        end
                        next_r.fill = r.fill + msz;
                        next_r.mem_left = r.mem_left - {13'h0, msz};
                    end else begin
                        next_r.fifo = r.fifo >> {msz, 3'h0};
                        next_r.fill = r.fill - msz;
                    end
                    if (mem_inc) begin
                        next_r.m_cur = r.m_cur + 32'(msz);
                    end
                    // lock drops with the last beat or with an error answer, never earlier
                    if (r.beats_left == 5'h01) begin
                        next_r.m_valid = 1'b0;
                        next_r.m_lock = 1'b0;
                        next_r.st = dse_pkg::DSE_IDLE;
                    end else begin
                        next_r.beats_left = r.beats_left - 5'h01;
                        next_r.m_addr = next_r.m_cur;
                        next_r.m_wdata = next_r.fifo[31:0];
                    end
                end
            end
            default: next_r.st = dse_pkg::DSE_IDLE;
        endcase
        // launch of an access from idle
        if (per_go) begin
            next_r.st = dse_pkg::DSE_PERIPH;
            next_r.p_valid = 1'b1;
            next_r.p_write = dir_m2p;
            next_r.p_lock = pbeats > 5'h01;
            next_r.p_size = periph_size;
            next_r.p_addr = r.p_cur;
            next_r.p_wdata = r.fifo[31:0];
            next_r.beats_left = pbeats;
        end
        if (mem_go) begin
            next_r.st = dse_pkg::DSE_MEM;
            next_r.m_valid = 1'b1;
            next_r.m_write = p2m;
            next_r.m_lock = mem_n > 5'h01;
            next_r.m_size = mem_item_size;
            next_r.m_addr = r.m_cur;
            next_r.m_wdata = r.fifo[31:0];
            next_r.beats_left = mem_n;
        end
        // end of block: flag, then stop or restart, on the other buffer in double-buffer mode
        if (blk_end) begin
            next_r.done_f = 1'b1;
            next_r.flush = 1'b0;
            next_r.fill = 5'h00;
            if (periph_length_control || !circ) begin
                next_r.enable = 1'b0;
            end else begin
                next_r.count = r.reload;
                next_r.mem_left = {2'h0, r.reload} << periph_size;
                next_r.p_cur = periph_port_address;
                if (double_buf) begin
                    next_r.ct = ~r.ct;
                    next_r.m_cur = r.ct ? r.mem_base_first : r.mem_base_second;
                end else begin
                    next_r.m_cur = r.ct ? r.mem_base_second : r.mem_base_first;
                end
            end
        end
        next_r.irq_half = next_r.half_f & half_ie;
        next_r.irq_done = next_r.done_f & done_ie;
        next_r.irq_err = next_r.err_f & err_ie;
    end

    // =========================================================
    // state register and outputs
    // =========================================================
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= dse_pkg::DSE_REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    assign stream_enable = r.enable;
    assign remaining_item_count = r.count;
    assign current_target_sel = r.ct;
    assign half_flag = r.half_f;
    assign done_flag = r.done_f;
    assign err_flag = r.err_f;
    assign irq_half = r.irq_half;
    assign irq_done = r.irq_done;
    assign irq_err = r.irq_err;
    assign stream_priority = r.prio;
    assign p_valid = r.p_valid;
    assign p_write = r.p_write;
    assign p_lock = r.p_lock;
    assign p_size = r.p_size;
    assign p_addr = r.p_addr;
    assign p_wdata = r.p_wdata;
    assign m_valid = r.m_valid;
    assign m_write = r.m_write;
    assign m_lock = r.m_lock;
    assign m_size = r.m_size;
    assign m_addr = r.m_addr;
    assign m_wdata = r.m_wdata;

    // =========================================================
    // checks
    // =========================================================
    default clocking dse_cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_periph_addr_step: assert property (per_beat && !p_err && periph_inc
        |=> r.p_cur == $past(r.p_cur) + 32'($past(psz)))
        else $error("peripheral address did not step by item size");
    a_periph_addr_hold: assert property (per_beat && !periph_inc
        |=> $stable(r.p_cur))
        else $error("fixed peripheral address moved");
    a_fill_by_size: assert property (per_beat && !p_err && p2m
        |=> r.fill == $past(r.fill) + $past(psz))
        else $error("fifo fill not advanced by source size");
    a_fifo_bound: assert property (r.fill <= dse_pkg::DSE_FIFO_BYTES)
        else $error("fifo overfilled");
    a_normal_stop: assert property (blk_end && !circ |=> !r.enable)
        else $error("normal block end left stream enabled");
    a_circ_reload: assert property (
        blk_end && circ && !periph_length_control
        |=> r.enable && r.count == $past(r.reload))
        else $error("circular reload missing");
    a_buffer_swap: assert property (
        blk_end && double_buf && !periph_length_control
        |=> r.ct != $past(r.ct))
        else $error("double buffer target not swapped");
    a_burst_lock: assert property (r.m_valid && r.beats_left > 5'h01
        |-> r.m_lock)
        else $error("memory burst not locked");
    a_count_dec: assert property (per_beat && !p_err && r.count != 16'h0
        |=> r.count == $past(r.count) - 16'h1)
        else $error("item counter not decremented");
    a_stop_hold: assert property (r.stop_pend && r.st != dse_pkg::DSE_IDLE
        && !(per_beat && p_err) && !(mem_beat && m_err)
        |=> r.enable)
        else $error("enable dropped during an access");
    a_base_guard: assert property (mem_base_first_wr && r.enable && !r.ct
        |=> $stable(r.mem_base_first))
        else $error("active memory pointer overwritten");
    a_direct_single: assert property (!fifo_en && mem_go |=> !r.m_lock)
        else $error("burst issued in direct mode");

    c_swap: cover property (blk_end && double_buf);
    c_burst: cover property (r.m_lock && mem_beat);
    c_stop: cover property (r.stop_pend ##1 !r.enable);
    c_normal_end: cover property (blk_end && !circ);
endmodule : dse_stream

//--- test/dse_bus_model.sv
// dse_bus_model: same-clock bus slave with a set number of wait states
`timescale 1ns/10ps
module dse_bus_model (
    input logic clk,
    input logic resetn,
    input logic valid,
    input logic [1:0] lat,
    output logic ready,
    output logic [31:0] rdata
);
    logic [1:0] wait_cnt;
    logic [31:0] pat;
    // ========================================
    // answer after lat waits; data is inverted outside the answer cycle
    assign ready = valid && (wait_cnt == lat);
    assign rdata = ready ? pat : ~pat;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt <= '0;
            pat <= 32'h5a;
        end else begin
            wait_cnt <= (valid && !ready) ? wait_cnt + 2'h1 : 2'h0;
            pat <= ready ? pat + 32'h1 : pat;
        end
    end
endmodule : dse_bus_model

//--- test/test_dse_stream.sv
// test_dse_stream: self-checking bench of one dma stream
`timescale 1ns/10ps
module test_dse_stream;
    typedef struct packed {
        logic [1:0] sz;
        logic inc, circ, db;
        logic [1:0] thr, mb;
        logic [15:0] n;
        logic [4:0] lk;
    } dse_row_t;
    logic clk = 0, resetn = 0, enable_wr = 0, enable_wdata = 0, count_wr = 0;
    logic mem_base_first_wr = 0, mem_base_second_wr = 0, dir_m2p = 0;
    logic periph_inc = 0, mem_inc = 1, circular = 0, double_buf = 0;
    logic fifo_en = 1, periph_length_control = 0, half_ie = 1, done_ie = 1;
    logic err_ie = 1, p_err = 0, m_err = 0, stream_enable, current_target_sel;
    logic half_flag, done_flag, err_flag, irq_half, irq_done, irq_err;
    logic p_valid, p_write, p_lock, p_ready, m_valid, m_write, m_lock, m_ready;
    logic [15:0] count_wdata = 0, remaining_item_count;
    logic [31:0] mem_base_first_wdata = 0, mem_base_second_wdata = 0;
    logic [31:0] periph_port_address = 32'h40000000, last_pa;
    logic [31:0] p_addr, p_wdata, p_rdata, m_addr, m_wdata, m_rdata;
    logic [1:0] periph_size = 0, mem_item_size = 0, fifo_thresh = 0;
    logic [1:0] periph_burst = 0, mem_burst_length = 0, p_size, m_size;
    logic [1:0] stream_priority_level = 2'h2, stream_priority;
    logic [1:0] p_lat = 2'h0, m_lat = 2'h2;
    logic [2:0] request_line_select = 3'h5, flag_clear = 0;
    logic [7:0] periph_req = 0, periph_last = 0;
    int err_total = 0, checks = 0, beats = 0, locked = 0;
    logic tgt = 0;
    // legal burst and threshold pairs, no memory-to-memory
    dse_row_t rows[4] = '{'{2'h0, 1'h1, 1'h0, 1'h0, 2'h0, 2'h0, 16'h6, 5'h0},
        '{2'h1, 1'h1, 1'h0, 1'h0, 2'h1, 2'h1, 16'h4, 5'h4},
        '{2'h2, 1'h0, 1'h0, 1'h1, 2'h3, 2'h1, 16'h4, 5'h4},
        '{2'h0, 1'h1, 1'h1, 1'h0, 2'h3, 2'h3, 16'h10, 5'h10}};

    dse_stream dse_stream_inst (.*);
    dse_bus_model p_dse_bus_model_inst (.clk(clk), .resetn(resetn),
        .valid(p_valid), .lat(p_lat), .ready(p_ready), .rdata(p_rdata));
    dse_bus_model m_dse_bus_model_inst (.clk(clk), .resetn(resetn),
        .valid(m_valid), .lat(m_lat), .ready(m_ready), .rdata(m_rdata));

    // ========================================
    // clock, beat counters, compare and verdict
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (p_valid && p_ready) begin
            beats <= beats + 1;
            last_pa <= p_addr;
        end
        if (m_valid && m_ready && m_lock) locked <= locked + 1;
    end
    task automatic chk(input string name, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", name, exp, got);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    // one block per row: program, enable, serve, check, stop
    task automatic run(input dse_row_t r);
        @(posedge clk);
        {periph_size, mem_item_size, periph_inc} <= {r.sz, r.sz, r.inc};
        {circular, double_buf, fifo_thresh} <= {r.circ, r.db, r.thr};
        mem_burst_length <= r.mb;
        count_wdata <= r.n;
        count_wr <= 1'h1;
        beats = 0;
        locked = 0;
        @(posedge clk);
        count_wr <= 1'h0;
        {enable_wr, enable_wdata} <= 2'h3;
        @(posedge clk);
        enable_wr <= 1'h0;
        periph_req <= 8'h20;
        for (int k = 0; k < 900 && done_flag !== 1'h1; k++) @(negedge clk);
        @(negedge clk);
        chk("done", 32'h1, done_flag);
        chk("half", 32'h1, half_flag);
        chk("irq_done", 32'h1, irq_done);
        chk("enable", r.circ | r.db, stream_enable);
        chk("count", (r.circ | r.db) ? r.n : 16'h0, remaining_item_count);
        tgt = tgt ^ r.db;
        chk("target", tgt, current_target_sel);
        chk("beats", r.n, beats);
        chk("locked", r.lk, locked);
        chk("addr", 32'h40000000 + (r.inc ? (r.n - 16'h1) << r.sz : 0), last_pa);
        @(posedge clk);
        periph_req <= 8'h00;
        {enable_wr, enable_wdata} <= 2'h2;
        @(posedge clk);
        enable_wr <= 1'h0;
        flag_clear <= 3'h7;
        for (int k = 0; k < 200 && stream_enable !== 1'h0; k++) @(negedge clk);
        chk("stopped", 32'h0, stream_enable);
        @(posedge clk);
        flag_clear <= 3'h0;
    endtask : run

    initial begin
        #750000;
        err_total++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'h1;
        foreach (rows[i]) run(rows[i]);
        // error answer on the peripheral port ends the stream
        @(posedge clk);
        p_err <= 1'h1;
        {enable_wr, enable_wdata} <= 2'h3;
        periph_req <= 8'h20;
        @(posedge clk);
        enable_wr <= 1'h0;
        for (int k = 0; k < 200 && err_flag !== 1'h1; k++) @(negedge clk);
        @(negedge clk);
        chk("err", 32'h1, irq_err);
        chk("err_stop", 32'h0, stream_enable);
        // second reset, after the error has stopped the stream, clears the state
        @(posedge clk);
        resetn <= 1'h0;
        @(negedge clk);
        chk("rst_flag", 32'h0, err_flag);
        chk("rst_count", 32'h0, remaining_item_count);
        results();
    end
endmodule : test_dse_stream
